// ==== verilog/digital_phase_locked_loop_lock_pkg.sv ====
package digital_phase_locked_loop_lock_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] word_t;
    typedef logic [15:0]       half_t;
    typedef logic [7:0]        index_t;

    // Register indices; the byte address is four times the index.
    localparam index_t IDX_LOCK_THRESHOLD        = 8'h47;
    localparam index_t IDX_LOCK_QUALIFY_INTERVAL = 8'h48;
    localparam index_t IDX_PHASE_SLEW_LIMIT      = 8'h49;
    localparam index_t IDX_REFERENCE_CHANGE_CTRL = 8'h4B;
    localparam index_t IDX_LOCK_STATUS           = 8'h50;
    localparam index_t IDX_EVENT_STATUS          = 8'h51;
    localparam index_t IDX_EVENT_MASK            = 8'h52;

    localparam addr_t ADR_LOCK_THRESHOLD        = addr_t'({IDX_LOCK_THRESHOLD, 2'b00});
    localparam addr_t ADR_LOCK_QUALIFY_INTERVAL = addr_t'({IDX_LOCK_QUALIFY_INTERVAL, 2'b00});
    localparam addr_t ADR_PHASE_SLEW_LIMIT      = addr_t'({IDX_PHASE_SLEW_LIMIT, 2'b00});
    localparam addr_t ADR_REFERENCE_CHANGE_CTRL = addr_t'({IDX_REFERENCE_CHANGE_CTRL, 2'b00});
    localparam addr_t ADR_LOCK_STATUS           = addr_t'({IDX_LOCK_STATUS, 2'b00});
    localparam addr_t ADR_EVENT_STATUS          = addr_t'({IDX_EVENT_STATUS, 2'b00});
    localparam addr_t ADR_EVENT_MASK            = addr_t'({IDX_EVENT_MASK, 2'b00});

    // Field widths and reset values.
    localparam int SLEW_W = 13;
    localparam int RCC_W  = 8;
    localparam int EVT_W  = 2;

    localparam half_t                 RST_LOCK_THRESHOLD = 16'h000F;
    localparam half_t                 RST_LOCK_QUALIFY   = 16'h0000;
    localparam logic [SLEW_W-1:0]     RST_SLEW_LIMIT     = 13'h099F;
    localparam logic [RCC_W-1:0]      RST_RCC            = 8'h00;
    localparam logic [EVT_W-1:0]      RST_EVT_MASK       = 2'h0;

    // Event and status bit positions.
    localparam int EVT_LOCK_GAINED = 0;
    localparam int EVT_LOCK_LOST   = 1;
    localparam int STAT_LOCKED     = 0;
    localparam int STAT_ABOVE      = 1;

    // Qualification timing.
    localparam int CORE_CLK_HZ      = 10_000_000;
    localparam int LOCK_UNIT_MS     = 4;
    localparam int LOCK_UNIT_CYCLES = LOCK_UNIT_MS * (CORE_CLK_HZ / 1000);
    localparam int LOSS_DIVIDER     = 256;
    localparam int DUR_W            = 24;

    typedef enum logic {
        ST_HUNT,
        ST_LOCKED
    } lock_state_t;

endpackage

// ==== verilog/digital_phase_locked_loop_lock_detect_slew_limit.sv ====
// What this block does
// - Lock declared only after phase stays at or under threshold for full interval.
// - Lock withheld or dropped after phase exceeds threshold for interval over 256.
// - Lock threshold is a 16-bit unsigned upper bound on absolute phase.
// - Qualification interval is a 16-bit unsigned count of 4 ms units.
// - A 13-bit unsigned limit caps the phase slope in either direction.
// - The slew limit resets to 0x099F, which is about plus 36.7 ppm.
// - Slew limit shares the centre frequency number scale of 2 to the 26.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps

module digital_phase_locked_loop_lock_detect_slew_limit #(
    parameter int UNIT_CYCLES = digital_phase_locked_loop_lock_pkg::LOCK_UNIT_CYCLES
) (
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_SRST,
    input  wire logic                  I_PSEL,
    input  wire logic                  I_PENABLE,
    input  wire logic                  I_PWRITE,
    input  wire digital_phase_locked_loop_lock_pkg::addr_t  I_PADDR,
    input  wire digital_phase_locked_loop_lock_pkg::word_t  I_PWDATA,
    output logic                       O_PREADY,
    output digital_phase_locked_loop_lock_pkg::word_t       O_PRDATA,
    output logic                       O_PSLVERR,
    input  wire digital_phase_locked_loop_lock_pkg::half_t  I_PHASE_ABS,
    input  wire digital_phase_locked_loop_lock_pkg::half_t  I_SLOPE_REQ,
    output digital_phase_locked_loop_lock_pkg::half_t       O_SLOPE_OUT,
    output logic                       O_LOCK,
    output logic [7:0]                 O_REF_CHANGE_CTRL,
    output logic                       O_IRQ
);
    import digital_phase_locked_loop_lock_pkg::*;

    // One sub-tick is one 256th of a qualification unit.
    localparam int SUB_RAW    = UNIT_CYCLES / LOSS_DIVIDER;
    localparam int SUB_CYCLES = (SUB_RAW < 1) ? 1 : SUB_RAW;
    localparam int SUB_W      = $clog2(SUB_CYCLES + 1);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SUB_CYCLES - 1);

    // Register file.
    half_t              lock_threshold_ff;
    half_t              lock_qualify_interval_ff;
    logic [SLEW_W-1:0]  phase_slew_limit_ff;
    logic [RCC_W-1:0]   reference_change_control_ff;
    logic [EVT_W-1:0]   evt_status_ff;
    logic [EVT_W-1:0]   evt_mask_ff;
    logic [EVT_W-1:0]   nxt_evt_status;
    logic [EVT_W-1:0]   evt_clear_ff;

    // Bus slave state.
    logic               pready_ff;
    word_t              prdata_ff;
    logic               pslverr_ff;

    // Lock detector state.
    lock_state_t        state_ff;
    lock_state_t        nxt_state;
    logic               above_ff;
    logic [SUB_W-1:0]   sub_cnt_ff;
    logic [SUB_W-1:0]   nxt_sub_cnt;
    logic [DUR_W-1:0]   dur_cnt_ff;
    logic [DUR_W-1:0]   nxt_dur_cnt;
    logic               irq_ff;
    logic               lock_ff;
    half_t              slope_out_ff;

    // APB decode.
    wire                setup     = I_PSEL & ~I_PENABLE;
    wire                complete  = I_PSEL & I_PENABLE & pready_ff;
    wire                wr_done   = complete & I_PWRITE;
    wire                rd_done   = complete & ~I_PWRITE;
    wire                sel_thr   = (I_PADDR == ADR_LOCK_THRESHOLD);
    wire                sel_qual  = (I_PADDR == ADR_LOCK_QUALIFY_INTERVAL);
    wire                sel_slew  = (I_PADDR == ADR_PHASE_SLEW_LIMIT);
    wire                sel_rcc   = (I_PADDR == ADR_REFERENCE_CHANGE_CTRL);
    wire                sel_lstat = (I_PADDR == ADR_LOCK_STATUS);
    wire                sel_estat = (I_PADDR == ADR_EVENT_STATUS);
    wire                sel_mask  = (I_PADDR == ADR_EVENT_MASK);
    wire                mapped    = sel_thr | sel_qual | sel_slew | sel_rcc |
                                    sel_lstat | sel_estat | sel_mask;
    wire                wr_thr    = wr_done & sel_thr;
    wire                wr_qual   = wr_done & sel_qual;
    wire                wr_slew   = wr_done & sel_slew;
    wire                wr_rcc    = wr_done & sel_rcc;
    wire                wr_mask   = wr_done & sel_mask;

    // Reserved bits are not stored, so they always read back as zero.
    wire word_t         rd_thr    = word_t'(lock_threshold_ff);
    wire word_t         rd_qual   = word_t'(lock_qualify_interval_ff);
    wire word_t         rd_slew   = word_t'(phase_slew_limit_ff);
    wire word_t         rd_rcc    = word_t'(reference_change_control_ff);
    wire [1:0]          lstat_bits;
    assign lstat_bits[STAT_LOCKED] = (state_ff == ST_LOCKED);
    assign lstat_bits[STAT_ABOVE]  = above_ff;
    wire word_t         rd_lstat  = word_t'(lstat_bits);
    wire word_t         rd_estat  = word_t'(evt_status_ff);
    wire word_t         rd_mask   = word_t'(evt_mask_ff);

    wire word_t         rd_mux    = sel_thr   ? rd_thr   :
                                    sel_qual  ? rd_qual  :
                                    sel_slew  ? rd_slew  :
                                    sel_rcc   ? rd_rcc   :
                                    sel_lstat ? rd_lstat :
                                    sel_estat ? rd_estat :
                                    sel_mask  ? rd_mask  : 32'h0000_0000;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
        end
    end

    // Read data is captured at setup, so it stands for the whole access phase.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= setup ? rd_mux : prdata_ff;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= setup & ~mapped;
        end
    end

    // Configuration registers. Reserved bits are dropped, which costs no storage.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            lock_threshold_ff <= RST_LOCK_THRESHOLD;
        end else if (wr_thr) begin
            lock_threshold_ff <= I_PWDATA[15:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            lock_qualify_interval_ff <= RST_LOCK_QUALIFY;
        end else if (wr_qual) begin
            lock_qualify_interval_ff <= I_PWDATA[15:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            phase_slew_limit_ff <= RST_SLEW_LIMIT;
        end else if (wr_slew) begin
            phase_slew_limit_ff <= I_PWDATA[SLEW_W-1:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            reference_change_control_ff <= RST_RCC;
        end else if (wr_rcc) begin
            reference_change_control_ff <= I_PWDATA[RCC_W-1:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            evt_mask_ff <= RST_EVT_MASK;
        end else if (wr_mask) begin
            evt_mask_ff <= I_PWDATA[EVT_W-1:0];
        end
    end

    // Lock detector: the comparison and its side of the threshold.
    wire                above       = (I_PHASE_ABS > lock_threshold_ff);
    wire                side_change = (above != above_ff);
    wire                sub_tick    = (sub_cnt_ff == SUB_LAST);
    wire                dur_full    = &dur_cnt_ff;

    // Lock needs interval*256 sub-ticks below; loss needs interval sub-ticks above.
    wire [DUR_W-1:0]    lock_target = DUR_W'({lock_qualify_interval_ff, 8'h00});
    wire [DUR_W-1:0]    loss_target = DUR_W'(lock_qualify_interval_ff);
    wire                lock_met    = ~above_ff & (dur_cnt_ff >= lock_target);
    wire                loss_met    = above_ff & (dur_cnt_ff >= loss_target);

    // Any crossing of the threshold throws away the time gathered so far.
    always_comb begin
        nxt_sub_cnt = sub_cnt_ff + SUB_W'(1);
        nxt_dur_cnt = dur_cnt_ff;
        if (side_change) begin
            nxt_sub_cnt = '0;
            nxt_dur_cnt = '0;
        end else if (sub_tick) begin
            nxt_sub_cnt = '0;
            if (!dur_full) begin
                nxt_dur_cnt = dur_cnt_ff + DUR_W'(1);
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_HUNT: begin
                if (lock_met && !side_change) begin
                    nxt_state = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (loss_met && !side_change) begin
                    nxt_state = ST_HUNT;
                end
            end
            default: begin
                nxt_state = ST_HUNT;
            end
        endcase
    end

    wire                gained = (state_ff == ST_HUNT) & (nxt_state == ST_LOCKED);
    wire                lost   = (state_ff == ST_LOCKED) & (nxt_state == ST_HUNT);

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            above_ff   <= 1'b1;
            sub_cnt_ff <= '0;
            dur_cnt_ff <= '0;
        end else begin
            above_ff   <= above;
            sub_cnt_ff <= nxt_sub_cnt;
            dur_cnt_ff <= nxt_dur_cnt;
        end
    end

    // The lock output is its own flip-flop, loaded from the next state so it moves with it.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            state_ff <= ST_HUNT;
            lock_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            lock_ff  <= (nxt_state == ST_LOCKED);
        end
    end

    // Events. A read clears only the bits it returned, and a new event wins over the clear.
    wire [EVT_W-1:0]    evt_set;
    assign evt_set[EVT_LOCK_GAINED] = gained;
    assign evt_set[EVT_LOCK_LOST]   = lost;

    always_comb begin
        nxt_evt_status = evt_status_ff;
        if (rd_done && sel_estat) begin
            nxt_evt_status = evt_status_ff & ~evt_clear_ff;
        end
        nxt_evt_status = nxt_evt_status | evt_set;
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            evt_status_ff <= '0;
        end else begin
            evt_status_ff <= nxt_evt_status;
        end
    end

    // Latching the returned bits at setup keeps an event that lands mid-read from being lost.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            evt_clear_ff <= '0;
        end else begin
            evt_clear_ff <= setup ? evt_status_ff : evt_clear_ff;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_evt_status & evt_mask_ff);
        end
    end

    // Slope cap. The limit is in centre frequency number units, the same scale as the
    // request, so no rescaling is needed here.
    wire signed [16:0]  req_s   = {I_SLOPE_REQ[15], I_SLOPE_REQ};
    wire signed [16:0]  lim_pos = $signed({4'h0, phase_slew_limit_ff});
    wire signed [16:0]  lim_neg = -lim_pos;
    wire                too_hi  = (req_s > lim_pos);
    wire                too_lo  = (req_s < lim_neg);
    wire half_t         slope_c = too_hi ? lim_pos[15:0] :
                                  too_lo ? lim_neg[15:0] : I_SLOPE_REQ;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            slope_out_ff <= 16'h0000;
        end else begin
            slope_out_ff <= slope_c;
        end
    end

    assign O_PREADY          = pready_ff;
    assign O_PRDATA          = prdata_ff;
    assign O_PSLVERR         = pslverr_ff;
    assign O_SLOPE_OUT       = slope_out_ff;
    assign O_LOCK            = lock_ff;
    assign O_REF_CHANGE_CTRL = reference_change_control_ff;
    assign O_IRQ             = irq_ff;

endmodule

// ==== tb/digital_phase_locked_loop_lock_checker.sv ====
`timescale 1ns/100ps
module digital_phase_locked_loop_lock_checker #(
    parameter int UNIT_CYCLES = 512
) (
    input wire logic                 I_CORE_CLK,
    input wire logic                 I_SRST,
    input wire logic                 I_PSEL,
    input wire logic                 I_PENABLE,
    input wire logic                 I_PWRITE,
    input wire digital_phase_locked_loop_lock_pkg::addr_t I_PADDR,
    input wire digital_phase_locked_loop_lock_pkg::word_t I_PWDATA,
    input wire logic                 O_PREADY,
    input wire digital_phase_locked_loop_lock_pkg::word_t O_PRDATA,
    input wire logic                 O_PSLVERR,
    input wire digital_phase_locked_loop_lock_pkg::half_t I_PHASE_ABS,
    input wire digital_phase_locked_loop_lock_pkg::half_t I_SLOPE_REQ,
    input wire digital_phase_locked_loop_lock_pkg::half_t O_SLOPE_OUT,
    input wire logic                 O_LOCK,
    input wire logic                 O_IRQ
);
    import digital_phase_locked_loop_lock_pkg::*;
    half_t thr_ff;
    logic  above;
    logic  rd_en;
    logic  mask_wr;
    // A shadow of the threshold tells the lock checks which side the phase is on.
    assign rd_en   = O_PREADY && !I_PWRITE;
    assign mask_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == ADR_EVENT_MASK;
    assign above   = I_PHASE_ABS > thr_ff;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            thr_ff <= RST_LOCK_THRESHOLD;
        end else if (O_PREADY && I_PWRITE && I_PADDR == ADR_LOCK_THRESHOLD) begin
            thr_ff <= I_PWDATA[15:0];
        end
    end
    function automatic int mag(input half_t v);
        return v[15] ? 32'h10000 - int'(v) : int'(v);
    endfunction
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SRST);
    pready_pulse_a: assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
    pready_setup_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY) else $error("no ready");
    slverr_ready_a: assert property (O_PSLVERR |-> O_PREADY) else $error("stray error");
    thr_read_a: assert property (rd_en && I_PADDR == ADR_LOCK_THRESHOLD |->
        O_PRDATA == {16'h0000, thr_ff}) else $error("threshold readback");
    slew_rsvd_a: assert property (rd_en && I_PADDR == ADR_PHASE_SLEW_LIMIT |->
        O_PRDATA[31:13] == 19'h00000) else $error("slew upper bits");
    slope_bound_a: assert property (!$past(I_SRST) |->
        mag(O_SLOPE_OUT) <= mag($past(I_SLOPE_REQ))) else $error("slope grew");
    lock_rise_a: assert property ($rose(O_LOCK) |-> !$past(above, 2))
        else $error("lock early");
    lock_fall_a: assert property ($fell(O_LOCK) |-> $past(above, 2))
        else $error("bad loss");
    irq_cause_a: assert property ($rose(O_IRQ) |-> $changed(O_LOCK) || $past(mask_wr, 2))
        else $error("irq without event");
    cover property ($rose(O_LOCK));
    cover property ($fell(O_LOCK));
    cover property (O_PSLVERR);
endmodule
bind digital_phase_locked_loop_lock_detect_slew_limit digital_phase_locked_loop_lock_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk_i (
    .I_CORE_CLK, .I_SRST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY,
    .O_PRDATA, .O_PSLVERR, .I_PHASE_ABS, .I_SLOPE_REQ, .O_SLOPE_OUT, .O_LOCK, .O_IRQ);

// ==== tb/digital_phase_locked_loop_lock_detect_slew_limit_bench.sv ====
`timescale 1ns/100ps
module digital_phase_locked_loop_lock_detect_slew_limit_bench;
    import digital_phase_locked_loop_lock_pkg::*;
    logic       clk;
    logic       srst = 1'b1;
    logic       psel = 1'b0;
    logic       pen = 1'b0;
    logic       pwr = 1'b0;
    addr_t      paddr = 12'h000;
    word_t      pwdata = 32'h0;
    half_t      phase = 16'hFFFF;
    half_t      sreq = 16'h0000;
    logic       pready, perr, lock, irq, er;
    word_t      prdata, rd;
    half_t      sout;
    logic [7:0] rcc;
    int         n_errors = 0;
    int         total_checks = 0;
    addr_t ra[5] = '{ADR_LOCK_QUALIFY_INTERVAL, ADR_LOCK_THRESHOLD, ADR_PHASE_SLEW_LIMIT,
                     ADR_REFERENCE_CHANGE_CTRL, ADR_EVENT_MASK};
    word_t rv[5] = '{32'h0, 32'hF, 32'h99F, 32'h0, 32'h0};
    word_t fv[5] = '{32'hFFFF, 32'hFFFF, 32'h1FFF, 32'hFF, 32'h3};
    half_t sq[4] = '{16'h0200, 16'hFE00, 16'h0080, 16'h0100};
    half_t se[4] = '{16'h0100, 16'hFF00, 16'h0080, 16'h0100};
    // A short unit keeps the lock interval near a thousand cycles.
    digital_phase_locked_loop_lock_detect_slew_limit #(.UNIT_CYCLES(512)) digital_phase_locked_loop_lock_detect_slew_limit_i (
        .I_CORE_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
        .O_PSLVERR(perr), .I_PHASE_ABS(phase), .I_SLOPE_REQ(sreq), .O_SLOPE_OUT(sout),
        .O_LOCK(lock), .O_REF_CHANGE_CTRL(rcc), .O_IRQ(irq));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string what, input word_t exp, input word_t got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input addr_t a, input word_t d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 16) begin
            k++;
            @(posedge clk);
        end
        chk("ready", 32'h0, (k == 16) ? 32'h1 : 32'h0);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string what, input addr_t a, input word_t exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic lock_is(input string what, input logic v);
        chk(what, {31'h0, v}, {31'h0, lock});
    endtask
    task automatic wait_lock(input logic v, input int n);
        for (int k = 0; k < n && lock !== v; k++) begin
            @(posedge clk);
        end
        lock_is("lock wait", v);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("outs", 32'h0, {sout, rcc, 6'h00, lock, irq});
        for (int i = 0; i < 5; i++) begin
            rdc("reset", ra[i], rv[i]);
        end
        // Qualify goes first so a wide threshold cannot lock at once.
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ra[i], fv[i]);
            rdc("fill", ra[i], fv[i]);
        end
        chk("refctl", 32'hFF, {24'h0, rcc});
        apb(1'b1, ra[3], 32'h0);
        apb(1'b1, 12'hFFC, 32'h1);
        rdc("unmapped", 12'hFFC, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        apb(1'b1, ADR_LOCK_THRESHOLD, 32'h282);
        apb(1'b1, ADR_PHASE_SLEW_LIMIT, 32'h100);
        apb(1'b1, ADR_LOCK_QUALIFY_INTERVAL, 32'h2);
        for (int i = 0; i < 4; i++) begin
            sreq <= sq[i];
            repeat (2) @(posedge clk);
            chk("slope", {16'h0, se[i]}, {16'h0, sout});
        end
        rdc("idle status", ADR_EVENT_STATUS, 32'h0);
        phase <= 16'h0282;
        repeat (600) @(posedge clk);
        phase <= 16'h0283;
        repeat (2) @(posedge clk);
        phase <= 16'h0282;
        repeat (950) @(posedge clk);
        lock_is("early lock", 1'b0);
        wait_lock(1'b1, 200);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("gained", ADR_EVENT_STATUS, 32'h1);
        chk("irq clear", 32'h0, {31'h0, irq});
        rdc("lock status", ADR_LOCK_STATUS, 32'h1);
        phase <= 16'h0283;
        repeat (2) @(posedge clk);
        phase <= 16'h0282;
        repeat (20) @(posedge clk);
        lock_is("blip", 1'b1);
        phase <= 16'hFFFF;
        repeat (3) @(posedge clk);
        lock_is("loss early", 1'b1);
        wait_lock(1'b0, 30);
        rdc("loss status", ADR_LOCK_STATUS, 32'h2);
        apb(1'b1, ADR_EVENT_MASK, 32'h1);
        // A new mask reaches the interrupt one edge after the write lands.
        @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, ADR_EVENT_MASK, 32'h3);
        @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        rdc("lost", ADR_EVENT_STATUS, 32'h2);
        chk("irq clear", 32'h0, {31'h0, irq});
        report_and_stop();
    end
endmodule
